// [sirq_defines.svh]
`ifndef SIRQ_DEFINES_SVH
`define SIRQ_DEFINES_SVH

`define SIRQ_OFS_SRC_SEL      4'h0
`define SIRQ_OFS_POLARITY     4'h4
`define SIRQ_OFS_STATUS       4'h8
`define SIRQ_RST_SRC_SEL      32'h00000000
`define SIRQ_RST_POLARITY     32'h00000000
`define SIRQ_SRC_WMASK        32'h001EFFFB
`define SIRQ_POL_WMASK        32'h001EFFFF
`define SIRQ_BIT_IRQ0         0
`define SIRQ_BIT_IRQ1         1
`define SIRQ_BIT_RSVD2        2
`define SIRQ_BIT_IRQ8         8
`define SIRQ_BIT_IRQ15        15
`define SIRQ_BIT_PCI_A        17
`define SIRQ_BIT_PCI_B        18
`define SIRQ_BIT_PCI_C        19
`define SIRQ_BIT_PCI_D        20
`define SIRQ_LINES            21
`define SIRQ_UNMAPPED_DATA    32'h00000000

`endif

// [sirq_lpc_model.sv]
`timescale 1ns/1ps

// Far-side serial peripherals: decoded frame levels per line
module sirq_lpc_model
    import sirq_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire sirq_pkg::sirq_lines_t req_lines,
    output sirq_pkg::sirq_lines_t      serial_irq_in
);
    import sirq_pkg::*;

    // A decoded level lands one frame clock after its request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            serial_irq_in <= '0;
        end else begin
            serial_irq_in <= req_lines;
        end
    end
endmodule

// [sirq_pkg.sv]
`include "sirq_defines.svh"

package sirq_pkg;
    typedef logic [`SIRQ_LINES-1:0] sirq_lines_t;
    typedef enum logic [1:0] {
        SIRQ_SRC_INTERNAL,
        SIRQ_SRC_PIN,
        SIRQ_SRC_SERIAL
    } sirq_src_kind_t;
endpackage

// [sirq_regfile.sv]
`timescale 1ns/1ps
`include "sirq_defines.svh"

// Two-word register store; read data registered
module sirq_regfile (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic        wr_idx,
    input  wire logic [31:0] wr_data,
    input  wire logic [31:0] wr_mask,
    input  wire logic        rd_idx,
    output logic      [31:0] rd_data,
    output logic      [31:0] word0,
    output logic      [31:0] word1
);
    logic [31:0] mem_r [0:1];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_r[0] <= `SIRQ_RST_SRC_SEL;
            mem_r[1] <= `SIRQ_RST_POLARITY;
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data & wr_mask;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= 32'h00000000;
        end else begin
            rd_data <= mem_r[rd_idx];
        end
    end

    assign word0 = mem_r[0];
    assign word1 = mem_r[1];
endmodule

// [sirq_route.sv]
`timescale 1ns/1ps
`include "sirq_defines.svh"

// Contract
// - Select bits 7,6,5,4,3,1 pick the internal request (0) or the serial stream (1).
// - Select bit 8 picks the internal clock-chip interrupt (0) or the serial stream (1).
// - Select bit 0 picks system timer channel 0 output (0) or the serial stream (1).
// - The polarity register is read/write in bits 20 to 17 and 15 to 0 and resets to all zero, active high.
// - Polarity bit 20 inverts serial-sourced PCI interrupt D when set.
// - Polarity bit 19 inverts serial-sourced PCI interrupt C when set.
// - Polarity bit 18 inverts serial-sourced PCI interrupt B when set.
// - Polarity bit 17 inverts serial-sourced PCI interrupt A when set.
// - Polarity bit 15 inverts serial-sourced line 15 when set.
// - Select bits 20 to 17 pick the PCI pin (0) or the serial stream (1) for D to A.
module sirq_route
    import sirq_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire sirq_pkg::sirq_lines_t isa_irq_in,
    input  wire logic              rtc_irq_in,
    input  wire logic              system_timer_channel0_output,
    input  wire logic [3:0]        pci_int_in,
    input  wire sirq_pkg::sirq_lines_t serial_irq_in,
    output sirq_pkg::sirq_lines_t  irq_out,
    output logic [31:0]            src_sel_out,
    output logic [31:0]            polarity_out
);
    import sirq_pkg::*;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_DONE
    } sirq_bus_state_t;

    sirq_bus_state_t bus_state_r;
    logic        wr_en;
    logic        wr_idx;
    logic        rd_idx;
    logic        hit;
    logic [31:0] wr_data;
    logic [31:0] wr_mask;
    logic [31:0] cur_word;
    logic [31:0] rf_rd_data;
    logic [31:0] src_word;
    logic [31:0] pol_word;
    logic        rd_hit_r;
    logic        rd_status_r;
    sirq_lines_t irq_nxt;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic sirq_src_kind_t kind_of(input int idx, input logic sel);
        if (sel) begin
            kind_of = SIRQ_SRC_SERIAL;
        end else if (idx >= `SIRQ_BIT_PCI_A) begin
            kind_of = SIRQ_SRC_PIN;
        end else begin
            kind_of = SIRQ_SRC_INTERNAL;
        end
    endfunction

    // Address decode
    always_comb begin
        hit    = 1'b0;
        wr_idx = 1'b0;
        if (avs_address == `SIRQ_OFS_SRC_SEL) begin
            hit    = 1'b1;
            wr_idx = 1'b0;
        end else if (avs_address == `SIRQ_OFS_POLARITY) begin
            hit    = 1'b1;
            wr_idx = 1'b1;
        end
    end
    assign rd_idx   = wr_idx;
    assign cur_word = wr_idx ? pol_word : src_word;

    // Write takes effect at the single edge where waitrequest is low
    assign wr_en   = avs_write && hit && (bus_state_r == BUS_IDLE) && !avs_waitrequest;
    // reserved bit 2
    // Select bit 2 is masked so a careless write cannot flip it
    assign wr_mask = wr_idx ? `SIRQ_POL_WMASK : `SIRQ_SRC_WMASK;
    assign wr_data = (avs_writedata & be_mask(avs_byteenable))
                   | (cur_word & ~be_mask(avs_byteenable));

    sirq_regfile u_regs (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_en),
        .wr_idx   (wr_idx),
        .wr_data  (wr_data),
        .wr_mask  (wr_mask),
        .rd_idx   (rd_idx),
        .rd_data  (rf_rd_data),
        .word0    (src_word),
        .word1    (pol_word)
    );

    // Bus sequencer: writes finish in one cycle, reads in two
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            case (bus_state_r)
                BUS_IDLE: begin
                    if (avs_read) begin
                        bus_state_r <= BUS_READ;
                    end
                end
                BUS_READ: begin
                    bus_state_r <= BUS_DONE;
                end
                BUS_DONE: begin
                    bus_state_r <= BUS_IDLE;
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_hit_r    <= 1'b0;
            rd_status_r <= 1'b0;
        end else if (bus_state_r == BUS_IDLE) begin
            rd_hit_r    <= hit;
            rd_status_r <= (avs_address == `SIRQ_OFS_STATUS);
        end
    end

    // Waitrequest registered; low only on the answer edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_state_r == BUS_IDLE && avs_write && !avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_state_r == BUS_IDLE && avs_write) begin
            avs_waitrequest <= 1'b0;
        end else if (bus_state_r == BUS_READ) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Status word shows the routed lines; unmapped reads return zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (bus_state_r == BUS_READ) begin
            if (rd_hit_r) begin
                avs_readdata <= rf_rd_data;
            end else if (rd_status_r) begin
                avs_readdata <= {{(32-`SIRQ_LINES){1'b0}}, irq_out};
            end else begin
                avs_readdata <= `SIRQ_UNMAPPED_DATA;
            end
        end
    end

    // Per-line source mux
    always_comb begin
        irq_nxt  = '0;
        for (int i = 0; i < `SIRQ_LINES; i++) begin
            case (kind_of(i, src_word[i]))
                SIRQ_SRC_SERIAL: irq_nxt[i] = serial_irq_in[i] ^ pol_word[i];
                SIRQ_SRC_PIN: irq_nxt[i] = pci_int_in[2'(i - `SIRQ_BIT_PCI_A)];
                default: irq_nxt[i] = isa_irq_in[i];
            endcase
        end
        if (!src_word[`SIRQ_BIT_IRQ8]) begin
            irq_nxt[`SIRQ_BIT_IRQ8] = rtc_irq_in;
        end
        // timer channel 0 on line 0
        if (!src_word[`SIRQ_BIT_IRQ0]) begin
            irq_nxt[`SIRQ_BIT_IRQ0] = system_timer_channel0_output;
        end
        irq_nxt[`SIRQ_BIT_RSVD2] = 1'b0;
        irq_nxt[16]              = 1'b0;
    end

    // Registered outputs; one cycle of latency traded for clean timing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_out      <= '0;
            src_sel_out  <= `SIRQ_RST_SRC_SEL;
            polarity_out <= `SIRQ_RST_POLARITY;
        end else begin
            irq_out      <= irq_nxt;
            src_sel_out  <= src_word;
            polarity_out <= pol_word;
        end
    end

    chk_pci_d_polarity: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && src_word[20])
            |=> irq_out[20] == ($past(serial_irq_in[20]) ^ $past(pol_word[20])))
        else $error("PCI D polarity wrong");
    chk_pci_c_polarity: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && src_word[19])
            |=> irq_out[19] == ($past(serial_irq_in[19]) ^ $past(pol_word[19])))
        else $error("PCI C polarity wrong");
    chk_pci_b_polarity: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && src_word[18])
            |=> irq_out[18] == ($past(serial_irq_in[18]) ^ $past(pol_word[18])))
        else $error("PCI B polarity wrong");
    chk_pci_a_polarity: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && src_word[17])
            |=> irq_out[17] == ($past(serial_irq_in[17]) ^ $past(pol_word[17])))
        else $error("PCI A polarity wrong");
    chk_irq15_polarity: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && src_word[15])
            |=> irq_out[15] == ($past(serial_irq_in[15]) ^ $past(pol_word[15])))
        else $error("line 15 polarity wrong");
    chk_pci_pin_path: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && !src_word[17]) |=> irq_out[17] == $past(pci_int_in[0]))
        else $error("PCI A pin path wrong");
    chk_rtc_line: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && !src_word[8]) |=> irq_out[8] == $past(rtc_irq_in))
        else $error("line 8 source wrong");
    chk_timer_line: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && !src_word[0]) |=> irq_out[0] == $past(system_timer_channel0_output))
        else $error("line 0 source wrong");
    chk_isa_line: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && !src_word[5]) |=> irq_out[5] == $past(isa_irq_in[5]))
        else $error("line 5 source wrong");
    chk_pol_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && !src_word[7] && pol_word[7]) |=> irq_out[7] == $past(isa_irq_in[7]))
        else $error("polarity leaked to internal");
    chk_rsvd_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
        !src_word[2] && !irq_out[2])
        else $error("reserved bit set");
    chk_read_latency: assert property (@(posedge core_clk) disable iff (sys_rst)
        (avs_read && bus_state_r == BUS_IDLE) |-> ##2 !avs_waitrequest)
        else $error("read latency wrong");

    cov_serial_inverted: cover property (@(posedge core_clk) src_word[20] && pol_word[20]);
    cov_pin_source: cover property (@(posedge core_clk) !src_word[17] && pci_int_in[0]);
    cov_write_done: cover property (@(posedge core_clk) wr_en);
    cov_read_done: cover property (@(posedge core_clk) bus_state_r == BUS_READ);
endmodule

// [sirq_tb.sv]
`timescale 1ns/1ps
`include "sirq_defines.svh"

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
    import sirq_pkg::*;
    logic        core_clk, sys_rst, avs_read, avs_write, rtc, tmr, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable, pci;
    logic [31:0] avs_writedata, avs_readdata, src_sel_out, polarity_out, rd, s, p, r;
    sirq_lines_t isa, ser_req, ser, irq_out;
    integer      num_errors, check_count, seed, n, i;

    sirq_lpc_model far (.core_clk(core_clk), .sys_rst(sys_rst), .req_lines(ser_req),
        .serial_irq_in(ser));
    sirq_route uut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .isa_irq_in(isa), .rtc_irq_in(rtc),
        .system_timer_channel0_output(tmr), .pci_int_in(pci), .serial_irq_in(ser),
        .irq_out(irq_out), .src_sel_out(src_sel_out), .polarity_out(polarity_out));

    function automatic sirq_lines_t exp_irq(logic [31:0] sv, logic [31:0] pv);
        sirq_lines_t e;
        e = isa;
        e[0] = tmr;
        e[8] = rtc;
        e[20:17] = pci;
        for (int k = 0; k < `SIRQ_LINES; k++) begin
            if (sv[k]) begin
                e[k] = ser_req[k] ^ pv[k];
            end
        end
        e[2] = 1'b0;
        e[16] = 1'b0;
        return e;
    endfunction

    // Held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        rd = avs_readdata;
        if (n >= 16) begin
            num_errors++;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task setr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
              input logic [31:0] e);
        bus(1'b1, a, d, be);
        bus(1'b0, a, 32'h00000000, 4'hF);
        `CHK(rd, e)
    endtask

    task route_chk;
        repeat (3) @(posedge core_clk);
        `CHK(irq_out, exp_irq(s, p))
        bus(1'b0, `SIRQ_OFS_STATUS, 32'h00000000, 4'hF);
        `CHK(rd, 32'(exp_irq(s, p)))
    endtask

    task results;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Whole run needs about a thousand cycles
    initial begin
        #1000000;
        num_errors++;
        results;
    end

    initial begin
        {avs_read, avs_write, rtc, tmr, pci, isa, ser_req} = '0;
        avs_address = 4'h0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h00000000;
        {num_errors, check_count, s, p} = '0;
        seed = 55;
        sys_rst = 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, `SIRQ_OFS_SRC_SEL, 32'h00000000, 4'hF);
        `CHK(rd, `SIRQ_RST_SRC_SEL)
        bus(1'b0, `SIRQ_OFS_POLARITY, 32'h00000000, 4'hF);
        `CHK(rd, 32'h00000000)
        `CHK(polarity_out, 32'h00000000)
        route_chk;
        $display("test reset done");
        // Software keeps select bit 2 clear
        setr(`SIRQ_OFS_SRC_SEL, 32'hFFFFFFFB, 4'hF, 32'h001EFFFB);
        setr(`SIRQ_OFS_POLARITY, 32'hFFFFFFFF, 4'hF, 32'h001EFFFF);
        setr(`SIRQ_OFS_POLARITY, 32'h00000000, 4'h4, 32'h0000FFFF);
        `CHK(polarity_out, 32'h0000FFFF)
        bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 4'hC, 32'h00000000, 4'hF);
        `CHK(rd, `SIRQ_UNMAPPED_DATA)
        `CHK(src_sel_out, 32'h001EFFFB)
        $display("test registers done");
        for (i = 0; i < 36; i++) begin
            if (i < 3) begin
                s = {32{i != 1}};
                p = {32{i != 0}};
            end else begin
                s = $random(seed);
                p = $random(seed);
            end
            // Reserved select bit written as zero
            s = s & ~32'h00000004;
            setr(`SIRQ_OFS_SRC_SEL, s, 4'hF, s & `SIRQ_SRC_WMASK);
            setr(`SIRQ_OFS_POLARITY, p, 4'hF, p & `SIRQ_POL_WMASK);
            s = s & `SIRQ_SRC_WMASK;
            p = p & `SIRQ_POL_WMASK;
            r = $random(seed);
            {rtc, tmr, pci, isa} <= r[26:0];
            r = $random(seed);
            ser_req <= r[20:0];
            route_chk;
            $display("test route %0d done", i);
        end
        // Mid-run reset must bring both words back to their reset values
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, `SIRQ_OFS_POLARITY, 32'h00000000, 4'hF);
        `CHK(rd, `SIRQ_RST_POLARITY)
        `CHK(src_sel_out, `SIRQ_RST_SRC_SEL)
        $display("test mid reset done");
        results;
    end
endmodule
